// ### hdl/touch_sync_pkg.sv
// Purpose: shared constants and carriers for the touch sync output timing block
// Assumes: registers are addressed by command page and 8-bit command address
// Notes:   field positions and defaults are kept here, the logic uses names only
// ==========================================================================
// package
package touch_sync_pkg;
  // ========================================================================
  // command page and register addresses
  localparam logic [7:0] SYNC_PAGE        = 8'h04;  // page that holds the sync bank
  localparam logic [7:0] FUNC_ENABLE_CODE = 8'h01;  // page 1 enabling value
  localparam logic [7:0] ADDR_MODE_CFG    = 8'h27;  // touch_sync_mode_config
  localparam logic [7:0] ADDR_LS_DELAY    = 8'h28;  // line_sync_delay
  localparam logic [7:0] ADDR_LS_HIGH     = 8'h29;  // line_sync_high_width
  localparam logic [7:0] ADDR_EN_POL      = 8'h2A;  // sync_output_enable_polarity
  // ========================================================================
  // reset values
  localparam logic [7:0] RST_MODE_CFG     = 8'h00;
  localparam logic [7:0] RST_LS_DELAY     = 8'h05;
  localparam logic [7:0] RST_LS_HIGH      = 8'h19;
  localparam logic [7:0] RST_EN_POL       = 8'hF0;
  localparam logic [7:0] EN_POL_RW_MASK   = 8'hF2;  // bits 3, 2 and 0 read as zero; bit 1 is stored as written
  // ========================================================================
  // field positions
  localparam int MODE_HI = 7;                       // sync_output_mode [7:6]
  localparam int MODE_LO = 6;
  localparam int FDLY_HI = 5;                       // frame_sync_line_delay [5:4]
  localparam int FDLY_LO = 4;
  localparam int LSAP_HI = 3;                       // line_sync_active_period_sel [3:2]
  localparam int LSAP_LO = 2;
  localparam int SRC_BIT = 1;                       // line_sync_source_sel
  localparam int FSW_BIT = 0;                       // frame_sync_width_option
  localparam int VS_EN_BIT  = 7;                    // frame_sync_output_enable
  localparam int HS_EN_BIT  = 6;                    // line_sync_output_enable
  localparam int VS_POL_BIT = 5;                    // frame_sync_polarity
  localparam int HS_POL_BIT = 4;                    // line_sync_polarity
  // ========================================================================
  // encodings and timing
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_VPORCH = 2'h1;
  localparam logic [1:0] MODE_ADJUST = 2'h2;
  localparam logic [1:0] MODE_VHPORCH = 2'h3;
  localparam logic [1:0] LSAP_ALL    = 2'h0;
  localparam logic [1:0] LSAP_ACT    = 2'h1;
  localparam logic [1:0] LSAP_PORCH  = 2'h2;
  localparam int OP_CLK_PERIOD_NS = 32;             // operating_clock_period
  localparam logic [2:0] FS_W_NORMAL = 3'h1;        // frame pulse widths in lines
  localparam logic [2:0] FS_W_ON     = 3'h3;
  localparam logic [2:0] FS_W_OFF    = 3'h2;
  localparam logic [2:0] FL_CNT_MAX  = 3'h7;
  // ========================================================================
  // carriers
  typedef struct packed {
    logic       wr;                                 // one-cycle write strobe
    logic       rd;                                 // one-cycle read strobe
    logic [7:0] page;                               // current command page
    logic [7:0] addr;                               // command address
    logic [7:0] wdata;                              // parameter byte
  } reg_req_t;
  typedef struct packed {
    logic op_tick;                                  // one pulse per operating clock
    logic line_start;                               // pulse at start of each line
    logic vertical_back_porch;                                      // vertical_back_porch level
    logic vertical_front_porch;                                      // vertical_front_porch level
    logic active_line_period;                                     // active_line_period level
    logic hporch;                                   // horizontal front or back porch
    logic prebuf_src;                               // pre-buffer source timing
    logic display_on;                               // display on state
  } disp_timing_t;
  typedef enum logic [1:0] {
    LS_IDLE  = 2'b00,
    LS_DELAY = 2'b01,
    LS_HIGH  = 2'b10
  } ls_state_t;
endpackage : touch_sync_pkg

// ### hdl/touch_sync_output_timing.sv
// Purpose: frame and line sync pulses for an external touch controller
// Assumes: timing inputs come from the display timing generator on clk_i
// Notes:   line widths and delays count operating clock ticks, not clk_i cycles; frame ones count lines
`timescale 1ns/10ps
`default_nettype none
module touch_sync_output_timing (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // register access from the command decoder
  input  wire touch_sync_pkg::reg_req_t    reg_req_i,
  input  wire logic [7:0]                  page1_sync_enable_i,
  output logic [7:0]                       rd_data_o,
  output logic                             rd_valid_o,
  // display timing
  input  wire touch_sync_pkg::disp_timing_t tmg_i,
  // touch controller pins
  output logic                             frame_sync_output_o,
  output logic                             line_sync_output_o
);
  import touch_sync_pkg::*;

  // ==========================================================================
  // register bank
  logic [7:0] mode_cfg_r,  mode_cfg_nxt;   // touch_sync_mode_config
  logic [7:0] ls_delay_r,  ls_delay_nxt;   // line_sync_delay
  logic [7:0] ls_high_r,   ls_high_nxt;    // line_sync_high_width
  logic [7:0] en_pol_r,    en_pol_nxt;     // sync_output_enable_polarity
  logic [7:0] rd_data_nxt;                 // read answer
  logic       rd_valid_nxt;                // read answer strobe
  logic       page_hit;                    // access aimed at the sync page

  // access is never gated by sleep or idle state
  always_comb begin
    page_hit     = (reg_req_i.page == SYNC_PAGE);
    mode_cfg_nxt = mode_cfg_r;
    ls_delay_nxt = ls_delay_r;
    ls_high_nxt  = ls_high_r;
    en_pol_nxt   = en_pol_r;
    rd_data_nxt  = rd_data_r_hold();
    rd_valid_nxt = 1'b0;
    if (reg_req_i.wr && page_hit) begin
      case (reg_req_i.addr)
        ADDR_MODE_CFG: mode_cfg_nxt = reg_req_i.wdata;
        ADDR_LS_DELAY: ls_delay_nxt = reg_req_i.wdata;
        ADDR_LS_HIGH:  ls_high_nxt  = reg_req_i.wdata;
        ADDR_EN_POL:   en_pol_nxt   = reg_req_i.wdata & EN_POL_RW_MASK;
        default: ;                                   // other addresses belong elsewhere
      endcase
    end
    if (reg_req_i.rd && page_hit) begin
      rd_valid_nxt = 1'b1;
      case (reg_req_i.addr)
        ADDR_MODE_CFG: rd_data_nxt = mode_cfg_r;
        ADDR_LS_DELAY: rd_data_nxt = ls_delay_r;
        ADDR_LS_HIGH:  rd_data_nxt = ls_high_r;
        ADDR_EN_POL:   rd_data_nxt = en_pol_r;
        default:       rd_data_nxt = 8'h00;          // unmapped reads as zero
      endcase
    end
  end

  // keeps the last answer on the pins between reads
  function automatic logic [7:0] rd_data_r_hold();
    return rd_data_o;
  endfunction : rd_data_r_hold

  // register the bank and the read answer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_cfg_r <= RST_MODE_CFG;
      ls_delay_r <= RST_LS_DELAY;
      ls_high_r  <= RST_LS_HIGH;
      en_pol_r   <= RST_EN_POL;
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      mode_cfg_r <= mode_cfg_nxt;
      ls_delay_r <= ls_delay_nxt;
      ls_high_r  <= ls_high_nxt;
      en_pol_r   <= en_pol_nxt;
      rd_data_o  <= rd_data_nxt;
      rd_valid_o <= rd_valid_nxt;
    end
  end

  // ==========================================================================
  // field decode
  logic [1:0] sync_output_mode;
  logic [1:0] frame_sync_line_delay;
  logic [1:0] line_sync_active_period_sel;
  logic       line_sync_source_sel;
  logic       frame_sync_width_option;
  logic       frame_sync_output_enable;
  logic       line_sync_output_enable;
  logic       frame_sync_polarity;
  logic       line_sync_polarity;
  logic       func_en;                     // page 1 enabling value present
  logic [7:0] high_eff;                    // high width, reserved zero acts as one

  assign sync_output_mode            = mode_cfg_r[MODE_HI:MODE_LO];
  assign frame_sync_line_delay       = mode_cfg_r[FDLY_HI:FDLY_LO];
  assign line_sync_active_period_sel = mode_cfg_r[LSAP_HI:LSAP_LO];
  assign line_sync_source_sel        = mode_cfg_r[SRC_BIT];
  assign frame_sync_width_option     = mode_cfg_r[FSW_BIT];
  assign frame_sync_output_enable    = en_pol_r[VS_EN_BIT];
  assign line_sync_output_enable     = en_pol_r[HS_EN_BIT];
  assign frame_sync_polarity         = en_pol_r[VS_POL_BIT];
  assign line_sync_polarity          = en_pol_r[HS_POL_BIT];
  assign func_en  = (page1_sync_enable_i == FUNC_ENABLE_CODE);
  // a zero width would never end the pulse, so it is clamped
  assign high_eff = (ls_high_r == 8'h00) ? 8'h01 : ls_high_r;

  // ==========================================================================
  // line sync generator
  ls_state_t  ls_state_r, ls_state_nxt;    // generator phase
  logic [7:0] ls_cnt_r,   ls_cnt_nxt;      // operating clocks in this phase

  // restart on every line, count only operating clock ticks
  always_comb begin
    ls_state_nxt = ls_state_r;
    ls_cnt_nxt   = ls_cnt_r;
    if (tmg_i.line_start) begin
      ls_cnt_nxt   = 8'h00;
      ls_state_nxt = (ls_delay_r == 8'h00) ? LS_HIGH : LS_DELAY;
    end else if (tmg_i.op_tick) begin
      case (ls_state_r)
        LS_DELAY: begin
          ls_cnt_nxt = ls_cnt_r + 8'h01;
          if (ls_cnt_nxt == ls_delay_r) begin
            ls_cnt_nxt   = 8'h00;
            ls_state_nxt = LS_HIGH;
          end
        end
        LS_HIGH: begin
          ls_cnt_nxt = ls_cnt_r + 8'h01;
          if (ls_cnt_nxt == high_eff) begin
            ls_cnt_nxt   = 8'h00;
            ls_state_nxt = LS_IDLE;
          end
        end
        LS_IDLE: ;                                // wait for the next line
        default: ls_state_nxt = LS_IDLE;
      endcase
    end
  end

  // register the generator
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ls_state_r <= LS_IDLE;
      ls_cnt_r   <= 8'h00;
    end else begin
      ls_state_r <= ls_state_nxt;
      ls_cnt_r   <= ls_cnt_nxt;
    end
  end

  // ==========================================================================
  // frame sync generator
  logic [2:0] fl_cnt_r,    fl_cnt_nxt;     // lines since back porch start
  logic       vbp_seen_r,  vbp_seen_nxt;   // first back porch line taken
  logic       fr_valid_r,  fr_valid_nxt;   // a back porch has been seen
  logic [2:0] fs_width_r,  fs_width_nxt;   // width for this frame in lines
  logic       pend_on_r,   pend_on_nxt;    // display turned on, not yet framed
  logic       pend_off_r,  pend_off_nxt;   // display turned off, not yet framed
  logic       disp_on_d_r, disp_on_d_nxt;  // display state one cycle ago
  logic       vbp_first;                   // line start on first back porch line
  logic [3:0] fs_end;                      // line count where the pulse ends

  always_comb begin
    vbp_first     = tmg_i.line_start && tmg_i.vertical_back_porch && !vbp_seen_r;
    fl_cnt_nxt    = fl_cnt_r;
    vbp_seen_nxt  = tmg_i.vertical_back_porch ? (vbp_seen_r || vbp_first) : 1'b0;
    fr_valid_nxt  = fr_valid_r || vbp_first;
    fs_width_nxt  = fs_width_r;
    disp_on_d_nxt = tmg_i.display_on;
    pend_on_nxt   = pend_on_r;
    pend_off_nxt  = pend_off_r;
    // align the line count to the first back porch line
    if (vbp_first) begin
      fl_cnt_nxt   = 3'h0;
      fs_width_nxt = FS_W_NORMAL;
      if (frame_sync_width_option && pend_on_r) begin
        fs_width_nxt = FS_W_ON;
      end else if (frame_sync_width_option && pend_off_r) begin
        fs_width_nxt = FS_W_OFF;
      end
      pend_on_nxt  = 1'b0;
      pend_off_nxt = 1'b0;
    end else if (tmg_i.line_start && fl_cnt_r != FL_CNT_MAX) begin
      fl_cnt_nxt = fl_cnt_r + 3'h1;
    end
    // a transition seen in the consuming cycle survives: set wins
    if (tmg_i.display_on && !disp_on_d_r) begin
      pend_on_nxt  = 1'b1;
      pend_off_nxt = 1'b0;
    end else if (!tmg_i.display_on && disp_on_d_r) begin
      pend_off_nxt = 1'b1;
      pend_on_nxt  = 1'b0;
    end
  end

  // register the frame generator
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fl_cnt_r    <= FL_CNT_MAX;
      vbp_seen_r  <= 1'b0;
      fr_valid_r  <= 1'b0;
      fs_width_r  <= FS_W_NORMAL;
      pend_on_r   <= 1'b0;
      pend_off_r  <= 1'b0;
      disp_on_d_r <= 1'b0;
    end else begin
      fl_cnt_r    <= fl_cnt_nxt;
      vbp_seen_r  <= vbp_seen_nxt;
      fr_valid_r  <= fr_valid_nxt;
      fs_width_r  <= fs_width_nxt;
      pend_on_r   <= pend_on_nxt;
      pend_off_r  <= pend_off_nxt;
      disp_on_d_r <= disp_on_d_nxt;
    end
  end

  // ==========================================================================
  // output selection
  logic fs_pulse;                          // adjustable frame pulse
  logic ls_gate;                           // line sync allowed in this line
  logic fs_raw;                            // frame level before polarity
  logic ls_raw;                            // line level before polarity
  logic fs_nxt;
  logic ls_nxt;

  // polarity one passes the level, zero inverts it
  function automatic logic apply_pol(input logic lvl, input logic pol);
    return pol ? lvl : ~lvl;
  endfunction : apply_pol

  always_comb begin
    fs_end   = {1'b0, frame_sync_line_delay} + {1'b0, fs_width_r};
    fs_pulse = fr_valid_r && ({1'b0, fl_cnt_r} >= {2'b00, frame_sync_line_delay})
               && ({1'b0, fl_cnt_r} < fs_end);
    case (line_sync_active_period_sel)
      LSAP_ALL:   ls_gate = tmg_i.active_line_period || tmg_i.vertical_front_porch || tmg_i.vertical_back_porch;
      LSAP_ACT:   ls_gate = tmg_i.active_line_period;
      LSAP_PORCH: ls_gate = tmg_i.vertical_front_porch || tmg_i.vertical_back_porch;
      default:    ls_gate = 1'b0;                                // reserved
    endcase
    case (sync_output_mode)
      MODE_VPORCH: begin
        fs_raw = tmg_i.vertical_front_porch || tmg_i.vertical_back_porch;
        ls_raw = 1'b0;
      end
      MODE_ADJUST: begin
        fs_raw = fs_pulse;
        ls_raw = ls_gate && (line_sync_source_sel ? (ls_state_r == LS_HIGH)
                                                  : tmg_i.prebuf_src);
      end
      MODE_VHPORCH: begin
        fs_raw = tmg_i.vertical_front_porch || tmg_i.vertical_back_porch;
        ls_raw = tmg_i.hporch;
      end
      default: begin
        fs_raw = 1'b0;
        ls_raw = 1'b0;
      end
    endcase
    // gated levels rest at the inactive level of their polarity
    fs_nxt = apply_pol(fs_raw && func_en && frame_sync_output_enable,
                       frame_sync_polarity);
    ls_nxt = apply_pol(ls_raw && func_en && line_sync_output_enable,
                       line_sync_polarity);
  end

  // output flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      frame_sync_output_o <= 1'b0;
      line_sync_output_o  <= 1'b0;
    end else begin
      frame_sync_output_o <= fs_nxt;
      line_sync_output_o  <= ls_nxt;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_line_start_nodelay;
    tmg_i.line_start && ls_delay_r == 8'h00;
  endsequence
  sequence s_high_last_tick;
    ls_state_r == LS_HIGH && tmg_i.op_tick && !tmg_i.line_start
      && ls_cnt_r + 8'h01 == high_eff;
  endsequence

  property p_func_gate;
    !func_en |=> frame_sync_output_o == !$past(frame_sync_polarity)
                 && line_sync_output_o == !$past(line_sync_polarity);
  endproperty
  a_func_gate: assert property (p_func_gate) else $error("sync active without enable");

  property p_mode_off;
    sync_output_mode == MODE_OFF |=> frame_sync_output_o == !$past(frame_sync_polarity);
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("frame sync active in off mode");

  property p_tick_only;
    ls_state_r == LS_DELAY && !tmg_i.op_tick && !tmg_i.line_start |=> $stable(ls_cnt_r);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("count moved without tick");

  property p_nodelay;
    s_line_start_nodelay |=> ls_state_r == LS_HIGH && ls_cnt_r == 8'h00;
  endproperty
  a_nodelay: assert property (p_nodelay) else $error("zero delay did not go high");

  property p_high_end;
    s_high_last_tick |=> ls_state_r == LS_IDLE;
  endproperty
  a_high_end: assert property (p_high_end) else $error("line high width wrong");

  property p_fs_disable;
    !frame_sync_output_enable |=> frame_sync_output_o == !$past(frame_sync_polarity);
  endproperty
  a_fs_disable: assert property (p_fs_disable) else $error("frame sync not suppressed");

  property p_ls_disable;
    !line_sync_output_enable |=> line_sync_output_o == !$past(line_sync_polarity);
  endproperty
  a_ls_disable: assert property (p_ls_disable) else $error("line sync not suppressed");

  property p_fs_porch_pol;
    func_en && sync_output_mode == MODE_VPORCH && frame_sync_output_enable
      && (tmg_i.vertical_front_porch || tmg_i.vertical_back_porch) |=> frame_sync_output_o == $past(frame_sync_polarity);
  endproperty
  a_fs_porch_pol: assert property (p_fs_porch_pol) else $error("frame polarity wrong");

  property p_ls_prebuf;
    func_en && sync_output_mode == MODE_ADJUST && line_sync_output_enable
      && !line_sync_source_sel && line_sync_active_period_sel == LSAP_ALL && tmg_i.active_line_period
      |=> line_sync_output_o == ($past(tmg_i.prebuf_src) ~^ $past(line_sync_polarity));
  endproperty
  a_ls_prebuf: assert property (p_ls_prebuf) else $error("line source select wrong");

  property p_vbp_align;
    tmg_i.line_start && tmg_i.vertical_back_porch && !vbp_seen_r |=> fl_cnt_r == 3'h0 ##1 fr_valid_r;
  endproperty
  a_vbp_align: assert property (p_vbp_align) else $error("frame count not aligned");
endmodule : touch_sync_output_timing
`default_nettype wire

// ### testbench/touch_ctrl_model.sv
// Purpose: touch controller model that measures sync pulses in op ticks and lines
// Assumes: both pins active high; line_start never shares a cycle with op_tick
// Notes:   a report leaves one cycle after each falling edge
`timescale 1ns/10ps
`default_nettype none
module touch_ctrl_model (
  // clock and timing reference
  input  wire logic        clk_i,
  input  wire logic        tick_i,
  input  wire logic        line_i,
  input  wire logic        mark_i,
  // sync pins
  input  wire logic        fs_i,
  input  wire logic        ls_i,
  // reports: {delay, width}
  output logic             ls_done_o,
  output logic [15:0]      ls_meas_o,
  output logic             fs_done_o,
  output logic [7:0]       fs_meas_o
);
  // ==========================================================
  // measurement counters
  logic [7:0] ld_r = 8'h00;            // ticks before the line pulse
  logic [7:0] lw_r = 8'h00;            // ticks while the line pulse is high
  logic [3:0] fl_r = 4'h0;             // lines since the first back porch line
  logic [3:0] fw_r = 4'h0;             // lines while the frame pulse is high
  logic [3:0] fd_r = 4'h0;             // line count seen at the frame rise
  logic       ls_q = 1'b0;
  logic       fs_q = 1'b0;
  logic       mk_q = 1'b0;
  // counts restart at every line, so a late pulse shows as a wrong delay
  always_ff @(posedge clk_i) begin
    ls_q <= ls_i;
    fs_q <= fs_i;
    ls_done_o <= ls_q & ~ls_i;
    fs_done_o <= fs_q & ~fs_i;
    ls_meas_o <= {ld_r, lw_r};
    fs_meas_o <= {fd_r, fw_r};
    if (line_i) begin
      ld_r <= 8'h00;
      lw_r <= 8'h00;
      mk_q <= mark_i;
      fl_r <= (mark_i & ~mk_q) ? 4'h0 : fl_r + 4'h1;
    end else if (tick_i & ls_i) begin
      lw_r <= lw_r + 8'h01;
    end else if (tick_i & (lw_r == 8'h00)) begin
      ld_r <= ld_r + 8'h01;
    end
    if (line_i & fs_i) begin
      fw_r <= fw_r + 4'h1;
    end else if (fs_i & ~fs_q) begin
      fw_r <= 4'h0;
      fd_r <= fl_r;
    end
  end
endmodule : touch_ctrl_model
`default_nettype wire

// ### testbench/touch_sync_output_timing_tb.sv
// Purpose: self-checking bench for the touch sync output timing block
// Assumes: op tick every fourth clock, lines long enough for delay plus width
// Notes:   expected results are queued and matched against reports as they appear
`timescale 1ns/10ps
`default_nettype none
module touch_sync_output_timing_tb;
  import touch_sync_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  reg_req_t     req = '0;
  logic [7:0]   pg1 = 8'h01;
  disp_timing_t tmg = '0;
  logic [7:0]   rdat, fsm, d, w;
  logic         rval, fs, ls, lsd, fsd, opt;
  logic [15:0]  lsm;
  logic [15:0]  q_ls[$];
  logic [7:0]   q_fs[$], q_rd[$];
  logic [7:0]   ad[4] = '{ADDR_MODE_CFG, ADDR_LS_DELAY, ADDR_LS_HIGH, ADDR_EN_POL};
  logic [7:0]   rv[4] = '{RST_MODE_CFG, RST_LS_DELAY, RST_LS_HIGH, RST_EN_POL};
  int           n_errors = 0;
  int           checks_done = 0;
  int           seed = 32'h92701a62;
  always #12.5 clk = ~clk;
  touch_sync_output_timing dut (.clk_i(clk), .rst_n_i(rst_n), .reg_req_i(req),
    .page1_sync_enable_i(pg1), .rd_data_o(rdat), .rd_valid_o(rval), .tmg_i(tmg),
    .frame_sync_output_o(fs), .line_sync_output_o(ls));
  touch_ctrl_model tc (.clk_i(clk), .tick_i(tmg.op_tick), .line_i(tmg.line_start),
    .mark_i(tmg.vertical_back_porch), .fs_i(fs), .ls_i(ls), .ls_done_o(lsd), .ls_meas_o(lsm),
    .fs_done_o(fsd), .fs_meas_o(fsm));
  // ==========================================================
  // tasks
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (e !== g) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr(logic [7:0] p, logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    req <= '{wr:1'b1, rd:1'b0, page:p, addr:a, wdata:v};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  // only page four answers, so only then is an answer expected
  task automatic rd(logic [7:0] p, logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    req <= '{wr:1'b0, rd:1'b1, page:p, addr:a, wdata:8'h00};
    if (p == SYNC_PAGE) q_rd.push_back(e);
    @(posedge clk);
    req.rd <= 1'b0;
  endtask : rd
  // one line of n clocks; ticks avoid the line_start cycle
  task automatic run_line(logic act, logic vf, logic vb, int n);
    @(posedge clk);
    tmg.line_start <= 1'b1;
    tmg.active_line_period <= act;
    tmg.vertical_front_porch <= vf;
    tmg.vertical_back_porch <= vb;
    for (int i = 1; i < n; i++) begin
      @(posedge clk);
      tmg.line_start <= 1'b0;
      tmg.op_tick <= (i % 4 == 2);
    end
  endtask : run_line
  task automatic close_out;
    cmp("pending results", 16'h0, 16'(q_ls.size() + q_fs.size() + q_rd.size()));
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  // ==========================================================
  // result watcher: each report takes the oldest note
  always @(posedge clk) begin
    if (rval === 1'b1) begin
      if (q_rd.size() == 0) cmp("rd_valid_o", 16'h0, 16'h1);
      else cmp("rd_data_o", {8'h00, q_rd.pop_front()}, {8'h00, rdat});
    end
    if (lsd === 1'b1) begin
      if (q_ls.size() == 0) cmp("line pulse", 16'h0, lsm);
      else cmp("line delay width", q_ls.pop_front(), lsm);
    end
    if (fsd === 1'b1) begin
      if (q_fs.size() == 0) cmp("frame pulse", 16'h0, {8'h00, fsm});
      else cmp("frame delay width", {8'h00, q_fs.pop_front()}, {8'h00, fsm});
    end
  end
  // watchdog, about four times the expected run length
  initial begin
    #500000;
    n_errors++;
    close_out();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(SYNC_PAGE, ad[i], rv[i]);
    rd(SYNC_PAGE, 8'h30, 8'h00);
    wr(8'h03, ADDR_LS_DELAY, 8'hAA);
    rd(8'h03, ADDR_LS_DELAY, 8'h00);
    rd(SYNC_PAGE, ADDR_LS_DELAY, RST_LS_DELAY);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed)) | 8'(i == 2);
      wr(SYNC_PAGE, ad[i], d);
      rd(SYNC_PAGE, ad[i], (i == 3) ? (d & EN_POL_RW_MASK) : d);
    end
    // porch levels and the pre-buffer source per mode
    wr(SYNC_PAGE, ADDR_EN_POL, 8'hF0);
    tmg <= '{vertical_front_porch:1'b1, hporch:1'b1, prebuf_src:1'b1, default:1'b0};
    for (int m = 0; m < 4; m++) begin
      wr(SYNC_PAGE, ADDR_MODE_CFG, {2'(m), 6'h00});
      repeat (3) @(posedge clk);
      cmp("frame_sync_output_o", 16'(m == 1 || m == 3), 16'(fs));
      cmp("line_sync_output_o", 16'(m >= 2), 16'(ls));
    end
    wr(SYNC_PAGE, ADDR_EN_POL, 8'h00);
    repeat (3) @(posedge clk);
    cmp("frame_sync_output_o", 16'h1, 16'(fs));
    cmp("line_sync_output_o", 16'h1, 16'(ls));
    wr(SYNC_PAGE, ADDR_EN_POL, 8'hC0);
    repeat (3) @(posedge clk);
    cmp("frame_sync_output_o", 16'h0, 16'(fs));
    cmp("line_sync_output_o", 16'h0, 16'(ls));
    tmg <= '0;
    // line generator over every active-period select and line kind
    wr(SYNC_PAGE, ADDR_EN_POL, 8'h70);
    for (int h = 0; h < 4; h++) begin
      for (int k = 0; k < 3; k++) begin
        d = 8'($unsigned($random(seed)) % 6);
        w = 8'(1 + $unsigned($random(seed)) % 5);
        wr(SYNC_PAGE, ADDR_MODE_CFG, {MODE_ADJUST, 2'b00, 2'(h), 1'b1, 1'b0});
        wr(SYNC_PAGE, ADDR_LS_DELAY, d);
        wr(SYNC_PAGE, ADDR_LS_HIGH, w);
        if (h == 0 || (h == 1 && k == 0) || (h == 2 && k != 0)) q_ls.push_back({d, w});
        run_line(k == 0, k == 1, k == 2, 4 * (d + w + 3));
      end
    end
    wr(SYNC_PAGE, ADDR_MODE_CFG, {MODE_ADJUST, 4'h0, 1'b1, 1'b0});
    wr(SYNC_PAGE, ADDR_LS_DELAY, 8'hFF);
    wr(SYNC_PAGE, ADDR_LS_HIGH, 8'hFF);
    q_ls.push_back(16'hFFFF);
    run_line(1'b1, 1'b0, 1'b0, 4 * 515);
    pg1 <= 8'h00;
    run_line(1'b1, 1'b0, 1'b0, 2100);
    pg1 <= 8'h01;
    // saturate the frame line count so no stale pulse fires on enable
    repeat (8) run_line(1'b0, 1'b1, 1'b0, 16);
    // frame pulse: delay, then widths around display transitions
    wr(SYNC_PAGE, ADDR_EN_POL, 8'hB0);
    for (int f = 0; f < 7; f++) begin
      opt = (f > 2);
      d = opt ? 8'h00 : 8'($unsigned($random(seed)) % 4);
      w = (f == 4) ? 8'h03 : (f == 6) ? 8'h02 : 8'h01;
      tmg.display_on <= (f == 4 || f == 5);
      wr(SYNC_PAGE, ADDR_MODE_CFG, {MODE_ADJUST, d[1:0], 2'b00, 1'b1, opt});
      q_fs.push_back({d[3:0], w[3:0]});
      repeat (4) run_line(1'b0, 1'b0, 1'b1, 16);
      run_line(1'b1, 1'b0, 1'b0, 16);
      run_line(1'b0, 1'b1, 1'b0, 16);
    end
    repeat (10) @(posedge clk);
    close_out();
  end
endmodule : touch_sync_output_timing_tb
`default_nettype wire
